// ==== rtl/ssom_pkg.sv ====
package ssom_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int ERR_W  = 32;
  localparam int SPD_W  = 16;
  localparam int SEL_W  = 3;
  localparam int N_OUT  = 3;
  localparam int N_FUNC = 5;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_RANGE  = 4'h0;
  localparam logic [3:0] OFS_WIDTH  = 4'h1;
  localparam logic [3:0] OFS_ZERO   = 4'h2;
  localparam logic [3:0] OFS_SEL_A  = 4'h3;
  localparam logic [3:0] OFS_SEL_B  = 4'h4;
  localparam logic [3:0] OFS_SEL_C  = 4'h5;
  localparam logic [3:0] OFS_MODE   = 4'h6;
  localparam logic [3:0] OFS_STATUS = 4'h7;
  localparam logic [3:0] OFS_ERR_LO = 4'h8;
  localparam logic [3:0] OFS_ERR_HI = 4'h9;

  // ---------------------------------------------------------------
  // reset values and setting limits
  // ---------------------------------------------------------------
  localparam logic [15:0] RANGE_RST = 16'h000A;
  localparam logic [15:0] RANGE_MAX = 16'h01F4;
  localparam logic [15:0] WIDTH_RST = 16'h000A;
  localparam logic [15:0] WIDTH_MAX = 16'h0064;
  localparam logic [15:0] ZERO_RST  = 16'h0014;
  localparam logic [15:0] ZERO_MAX  = 16'h09C4;
  localparam logic [2:0]  SEL_A_RST = 3'h0;
  localparam logic [2:0]  SEL_B_RST = 3'h1;
  localparam logic [2:0]  SEL_C_RST = 3'h2;
  localparam logic [2:0]  SEL_MAX   = 3'h4;

  // ---------------------------------------------------------------
  // output function codes
  // ---------------------------------------------------------------
  localparam logic [2:0] FN_DONE    = 3'h0;
  localparam logic [2:0] FN_RUNNING = 3'h1;
  localparam logic [2:0] FN_READY   = 3'h2;
  localparam logic [2:0] FN_TORQUE  = 3'h3;
  localparam logic [2:0] FN_BRAKE   = 3'h4;

  typedef enum logic [1:0] {
    MODE_POS    = 2'b00,
    MODE_SPEED  = 2'b01,
    MODE_TORQUE = 2'b10
  } ssom_mode_t;
endpackage

// ==== rtl/ssom_cmp_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface ssom_cmp_if;
  logic [ssom_pkg::ERR_W-1:0]  err_count;
  logic [ssom_pkg::SPD_W-1:0]  ref_speed;
  logic [ssom_pkg::SPD_W-1:0]  motor_speed;
  logic [ssom_pkg::DATA_W-1:0] done_range;
  logic [ssom_pkg::DATA_W-1:0] match_width;
  logic [ssom_pkg::DATA_W-1:0] zero_level;
  logic                        err_in_range;
  logic                        speed_match;
  logic                        running;

  modport top (
    output err_count, ref_speed, motor_speed,
    output done_range, match_width, zero_level,
    input  err_in_range, speed_match, running
  );
  modport cmp (
    input  err_count, ref_speed, motor_speed,
    input  done_range, match_width, zero_level,
    output err_in_range, speed_match, running
  );
endinterface
`default_nettype wire

// ==== rtl/ssom_compare.sv ====
`timescale 1ns/100ps
`default_nettype none
module ssom_compare (
  // operands and results
  ssom_cmp_if.cmp c
);
  // ---------------------------------------------------------------
  // magnitudes, widened so the most negative value negates cleanly
  // ---------------------------------------------------------------
  wire logic [32:0] err_ext;
  wire logic [32:0] err_mag;
  wire logic [17:0] diff;
  wire logic [17:0] diff_mag;
  wire logic [16:0] mot_ext;
  wire logic [16:0] mot_mag;

  assign err_ext  = {c.err_count[31], c.err_count};
  assign err_mag  = err_ext[32] ? (~err_ext + 33'h1) : err_ext;
  assign diff     = {{2{c.ref_speed[15]}}, c.ref_speed}
                  - {{2{c.motor_speed[15]}}, c.motor_speed};
  assign diff_mag = diff[17] ? (~diff + 18'h1) : diff;
  assign mot_ext  = {c.motor_speed[15], c.motor_speed};
  assign mot_mag  = mot_ext[16] ? (~mot_ext + 17'h1) : mot_ext;

  // ---------------------------------------------------------------
  // threshold compares
  // ---------------------------------------------------------------
  // strictly below the range counts as done
  assign c.err_in_range = err_mag < {17'h0, c.done_range};
  // equal to the width still counts as a match
  assign c.speed_match  = diff_mag <= {2'h0, c.match_width};
  // equal to the level counts as stopped
  assign c.running      = mot_mag > {1'h0, c.zero_level};
endmodule // ssom_compare
`default_nettype wire

// ==== rtl/ssom_top.sv ====
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - in position mode, done is on while error magnitude is below range
// - completion range setting accepts 0 to 500, resets to 10
// - error count is compared in reference units, not encoder counts
// - in position mode, done also needs a reference pulse seen and the pulse train finished
// - torque mode holds done and speed match permanently on
// - code 0 carries done in position mode, speed match in speed mode
// - speed match is on while speed difference magnitude is within width
// - speed match width accepts 0 to 100 rpm, resets to 10
// - running is on while speed magnitude exceeds zero-speed level
// - zero-speed level accepts 0 to 2500 rpm, resets to 20
// - ready is on when main power is up and no alarm is active
// - three selectors accept 0 to 4, reset to 0, 1 and 2
// - codes: done/match, running, ready, torque limit, brake interlock
// - every output line is low when its status is on
// - 32-bit error count is read as a low and a high 16-bit word
module ssom_top (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        nrst_i,
  // register port
  input  wire logic [ssom_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [ssom_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [ssom_pkg::DATA_W-1:0] rdata_o,
  // drive measurements
  input  wire logic [ssom_pkg::ERR_W-1:0]  err_count_i,
  input  wire logic [ssom_pkg::SPD_W-1:0]  ref_speed_i,
  input  wire logic [ssom_pkg::SPD_W-1:0]  motor_speed_i,
  input  wire logic                        ref_pulse_i,
  input  wire logic                        ref_busy_i,
  // drive condition
  input  wire logic                        main_power_i,
  input  wire logic                        alarm_i,
  input  wire logic                        torque_limited_i,
  input  wire logic                        brake_interlock_i,
  // status output lines, active low
  output logic      [ssom_pkg::N_OUT-1:0]  out_n_o
);
  // ---------------------------------------------------------------
  // input registers
  // ---------------------------------------------------------------
  logic [ssom_pkg::ERR_W-1:0] err_reg;
  logic [ssom_pkg::SPD_W-1:0] rspd_reg;
  logic [ssom_pkg::SPD_W-1:0] mspd_reg;
  logic                       pulse_reg;
  logic                       busy_reg;
  logic                       pwr_reg;
  logic                       alm_reg;
  logic                       tlim_reg;
  logic                       brk_reg;

  // all compares read these, never the pins
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      err_reg   <= 32'h0;
      rspd_reg  <= 16'h0;
      mspd_reg  <= 16'h0;
      pulse_reg <= 1'b0;
      busy_reg  <= 1'b0;
      pwr_reg   <= 1'b0;
      alm_reg   <= 1'b0;
      tlim_reg  <= 1'b0;
      brk_reg   <= 1'b0;
    end
    else
    begin
      err_reg   <= err_count_i;
      rspd_reg  <= ref_speed_i;
      mspd_reg  <= motor_speed_i;
      pulse_reg <= ref_pulse_i;
      busy_reg  <= ref_busy_i;
      pwr_reg   <= main_power_i;
      alm_reg   <= alarm_i;
      tlim_reg  <= torque_limited_i;
      brk_reg   <= brake_interlock_i;
    end
  end

  // ---------------------------------------------------------------
  // settings
  // ---------------------------------------------------------------
  logic [15:0]         range_reg;
  logic [15:0]         width_reg;
  logic [15:0]         zero_reg;
  logic [2:0]          sel_reg [ssom_pkg::N_OUT];
  ssom_pkg::ssom_mode_t mode_reg;

  // out-of-range writes saturate rather than wrap
  function automatic logic [15:0] sat16(input logic [15:0] v,
                                        input logic [15:0] mx);
    sat16 = (v > mx) ? mx : v;
  endfunction

  wire logic        wr_range;
  wire logic        wr_width;
  wire logic        wr_zero;
  wire logic        wr_mode;
  wire logic [2:0]  sel_wval;
  wire logic [1:0]  mode_wval;

  assign wr_range  = wr_i && (addr_i == ssom_pkg::OFS_RANGE);
  assign wr_width  = wr_i && (addr_i == ssom_pkg::OFS_WIDTH);
  assign wr_zero   = wr_i && (addr_i == ssom_pkg::OFS_ZERO);
  assign wr_mode   = wr_i && (addr_i == ssom_pkg::OFS_MODE);
  assign sel_wval  = (wdata_i > {13'h0, ssom_pkg::SEL_MAX})
                   ? ssom_pkg::SEL_MAX : wdata_i[2:0];
  // an undefined mode code falls back to torque
  assign mode_wval = (wdata_i > 16'h0002) ? 2'b10 : wdata_i[1:0];

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      range_reg <= ssom_pkg::RANGE_RST;
      width_reg <= ssom_pkg::WIDTH_RST;
      zero_reg  <= ssom_pkg::ZERO_RST;
      mode_reg  <= ssom_pkg::MODE_POS;
    end
    else
    begin
      if (wr_range)
        range_reg <= sat16(wdata_i, ssom_pkg::RANGE_MAX);
      if (wr_width)
        width_reg <= sat16(wdata_i, ssom_pkg::WIDTH_MAX);
      if (wr_zero)
        zero_reg  <= sat16(wdata_i, ssom_pkg::ZERO_MAX);
      if (wr_mode)
        mode_reg  <= ssom_pkg::ssom_mode_t'(mode_wval);
    end
  end

  // ---------------------------------------------------------------
  // selectors, one per output line
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL_RST [ssom_pkg::N_OUT] =
    '{ssom_pkg::SEL_A_RST, ssom_pkg::SEL_B_RST, ssom_pkg::SEL_C_RST};
  localparam logic [3:0] SEL_OFS [ssom_pkg::N_OUT] =
    '{ssom_pkg::OFS_SEL_A, ssom_pkg::OFS_SEL_B, ssom_pkg::OFS_SEL_C};

  logic [4:0]                func_vec;
  logic [ssom_pkg::N_OUT-1:0] out_n_reg;

  for (genvar g = 0; g < ssom_pkg::N_OUT; g++)
  begin : g_out
    wire logic wr_sel;
    wire logic fn_on;

    assign wr_sel = wr_i && (addr_i == SEL_OFS[g]);
    // saturated writes keep the index inside func_vec
    assign fn_on  = func_vec[sel_reg[g]];

    always_ff @(posedge clk_i)
    begin
      if (!nrst_i)
      begin
        sel_reg[g]   <= SEL_RST[g];
        out_n_reg[g] <= 1'b1;
      end
      else
      begin
        if (wr_sel)
          sel_reg[g] <= sel_wval;
        out_n_reg[g] <= ~fn_on;
      end
    end
  end

  // ---------------------------------------------------------------
  // compares and status functions
  // ---------------------------------------------------------------
  ssom_cmp_if cif ();

  assign cif.err_count   = err_reg;
  assign cif.ref_speed   = rspd_reg;
  assign cif.motor_speed = mspd_reg;
  assign cif.done_range  = range_reg;
  assign cif.match_width = width_reg;
  assign cif.zero_level  = zero_reg;

  ssom_compare u_cmp (
    .c (cif.cmp)
  );

  // a move counts only once a pulse arrived and the train ended
  logic ref_seen_reg;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      ref_seen_reg <= 1'b0;
    else if (pulse_reg)
      ref_seen_reg <= 1'b1;
    else if (mode_reg != ssom_pkg::MODE_POS)
      ref_seen_reg <= 1'b0;
  end

  wire logic pos_done;
  wire logic done_fn;

  assign pos_done = ref_seen_reg && !busy_reg
                  && cif.err_in_range;
  // done and speed match share code 0
  assign done_fn  = (mode_reg == ssom_pkg::MODE_TORQUE) ? 1'b1
                  : (mode_reg == ssom_pkg::MODE_SPEED)
                  ? cif.speed_match : pos_done;

  assign func_vec[ssom_pkg::FN_DONE]    = done_fn;
  assign func_vec[ssom_pkg::FN_RUNNING] = cif.running;
  assign func_vec[ssom_pkg::FN_READY]   = pwr_reg && !alm_reg;
  assign func_vec[ssom_pkg::FN_TORQUE]  = tlim_reg;
  assign func_vec[ssom_pkg::FN_BRAKE]   = brk_reg;

  logic [4:0] stat_reg;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      stat_reg <= 5'h0;
    else
      stat_reg <= func_vec;
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // reading the low word freezes the high word for a coherent pair
  logic [15:0] err_hi_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rd_mux;

  always_comb
  begin
    unique case (addr_i)
      ssom_pkg::OFS_RANGE:  rd_mux = range_reg;
      ssom_pkg::OFS_WIDTH:  rd_mux = width_reg;
      ssom_pkg::OFS_ZERO:   rd_mux = zero_reg;
      ssom_pkg::OFS_SEL_A:  rd_mux = {13'h0, sel_reg[0]};
      ssom_pkg::OFS_SEL_B:  rd_mux = {13'h0, sel_reg[1]};
      ssom_pkg::OFS_SEL_C:  rd_mux = {13'h0, sel_reg[2]};
      ssom_pkg::OFS_MODE:   rd_mux = {14'h0, mode_reg};
      ssom_pkg::OFS_STATUS: rd_mux = {5'h0, out_n_reg, 2'h0,
                                      ref_seen_reg, stat_reg};
      ssom_pkg::OFS_ERR_LO: rd_mux = err_reg[15:0];
      ssom_pkg::OFS_ERR_HI: rd_mux = err_hi_reg;
      default:              rd_mux = 16'h0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      rdata_reg  <= 16'h0;
      err_hi_reg <= 16'h0;
    end
    else
    begin
      rdata_reg <= rd_i ? rd_mux : 16'h0;
      if (rd_i && (addr_i == ssom_pkg::OFS_ERR_LO))
        err_hi_reg <= err_reg[31:16];
    end
  end

  assign rdata_o = rdata_reg;
  assign out_n_o = out_n_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  wire logic is_pos;
  wire logic is_spd;
  wire logic is_trq;

  assign is_pos = mode_reg == ssom_pkg::MODE_POS;
  assign is_spd = mode_reg == ssom_pkg::MODE_SPEED;
  assign is_trq = mode_reg == ssom_pkg::MODE_TORQUE;

  sequence s_lo_read;
    rd_i && (addr_i == ssom_pkg::OFS_ERR_LO);
  endsequence
  sequence s_hi_read;
    rd_i && (addr_i == ssom_pkg::OFS_ERR_HI) && !wr_i;
  endsequence

  done_on_a: assert property (
    is_pos && ref_seen_reg && !busy_reg && cif.err_in_range
    |=> stat_reg[0])
    else $error("done not set inside range");
  done_off_a: assert property (
    is_pos && !cif.err_in_range |=> !stat_reg[0])
    else $error("done set outside range");
  range_max_a: assert property (
    range_reg <= ssom_pkg::RANGE_MAX)
    else $error("range above limit");
  pulse_seen_a: assert property (
    is_pos && !ref_seen_reg |=> !stat_reg[0])
    else $error("done before any reference pulse");
  torque_on_a: assert property (
    is_trq && sel_reg[0] == ssom_pkg::FN_DONE
    |=> stat_reg[0] && !out_n_reg[0])
    else $error("torque mode done not held on");
  match_sel_a: assert property (
    is_spd |=> stat_reg[0] == $past(cif.speed_match))
    else $error("speed match wrong");
  running_a: assert property (
    stat_reg[1] == $past(cif.running, 1))
    else $error("running status wrong");
  ready_a: assert property (
    stat_reg[2] == $past(pwr_reg && !alm_reg))
    else $error("ready status wrong");
  low_active_a: assert property (
    sel_reg[1] == $past(sel_reg[1]) |->
    out_n_reg[1] == !$past(func_vec[sel_reg[1]]))
    else $error("output line not active low");
  same_code_a: assert property (
    sel_reg[0] == sel_reg[1] ##1 sel_reg[0] == sel_reg[1]
    |-> out_n_reg[0] == out_n_reg[1])
    else $error("shared code differs on lines");
  hi_pair_a: assert property (
    s_lo_read ##1 s_hi_read |=> rdata_reg == $past(err_reg[31:16], 2))
    else $error("high word not paired with low");
endmodule // ssom_top
`default_nettype wire

// ==== dv/ssom_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------
// host controller: one move, then interlock wait
// ----------------------------------------------
module ssom_host_model #(
  parameter int WAIT_MAX = 8
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // move request, busy length sets prompt or slow
  input  wire logic       start_i,
  input  wire logic [3:0] busy_len_i,
  // interlock line from the drive, active low
  input  wire logic       done_n_i,
  // reference pulse train and interlock result
  output logic            ref_pulse_o = 1'b0,
  output logic            ref_busy_o  = 1'b0,
  output logic            confirmed_o = 1'b0
);
  int phase = 0;
  int cnt   = 0;

  always @(posedge clk_i)
  begin
    ref_pulse_o <= 1'b0;
    if (!nrst_i)
    begin
      phase       <= 0;
      ref_busy_o  <= 1'b0;
      confirmed_o <= 1'b0;
    end
    else if (phase == 0 && start_i)
    begin
      ref_pulse_o <= 1'b1;
      ref_busy_o  <= 1'b1;
      confirmed_o <= 1'b0;
      cnt         <= busy_len_i;
      phase       <= 1;
    end
    else if (phase == 1)
    begin
      cnt <= cnt - 1;
      if (cnt <= 1)
      begin
        ref_busy_o <= 1'b0;
        cnt        <= WAIT_MAX;
        phase      <= 2;
      end
    end
    else if (phase == 2)
    begin
      // next move once the drive reports done or the WAIT_MAX wait runs out
      cnt <= cnt - 1;
      if (!done_n_i)
        confirmed_o <= 1'b1;
      if (!done_n_i || cnt == 0)
        phase <= 0;
    end
  end
endmodule // ssom_host_model
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [3:0]  addr_i = '0;
  logic [15:0] wdata_i = '0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] err_count_i = '0;
  logic [15:0] ref_speed_i = '0;
  logic [15:0] motor_speed_i = '0;
  logic        main_power_i = 1'b1;
  logic        alarm_i = 1'b0;
  logic        torque_limited_i = 1'b0;
  logic        brake_interlock_i = 1'b0;
  logic        start = 1'b0;
  logic [3:0]  busy_len = 4'h1;
  wire logic [15:0] rdata_o;
  wire logic [2:0]  out_n_o;
  wire logic        ref_pulse;
  wire logic        ref_busy;
  wire logic        confirmed;
  int n_errors = 0;
  int compares = 0;
  int seed = 94;
  int m_set[7];
  int m_seen, m_err, m_ref, m_mot;
  int mx_t[7] = '{ssom_pkg::RANGE_MAX, ssom_pkg::WIDTH_MAX,
    ssom_pkg::ZERO_MAX, ssom_pkg::SEL_MAX, ssom_pkg::SEL_MAX,
    ssom_pkg::SEL_MAX, 2};
  int rst_t[7] = '{ssom_pkg::RANGE_RST, ssom_pkg::WIDTH_RST,
    ssom_pkg::ZERO_RST, ssom_pkg::SEL_A_RST, ssom_pkg::SEL_B_RST,
    ssom_pkg::SEL_C_RST, 0};

  always #12.5 clk_i = ~clk_i;

  ssom_top ssom_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .err_count_i(err_count_i), .ref_speed_i(ref_speed_i),
    .motor_speed_i(motor_speed_i), .ref_pulse_i(ref_pulse),
    .ref_busy_i(ref_busy), .main_power_i(main_power_i),
    .alarm_i(alarm_i), .torque_limited_i(torque_limited_i),
    .brake_interlock_i(brake_interlock_i), .out_n_o(out_n_o));

  ssom_host_model ssom_host_model_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .start_i(start), .busy_len_i(busy_len), .done_n_i(out_n_o[0]),
    .ref_pulse_o(ref_pulse), .ref_busy_o(ref_busy),
    .confirmed_o(confirmed));

  // ----------------------------------------------
  // reference model
  // ----------------------------------------------
  function automatic int rnd(input int n);
    return {$random(seed)} % n;
  endfunction

  function automatic int iabs(input int v);
    return (v < 0) ? -v : v;
  endfunction

  function automatic logic [4:0] exp_st();
    logic dn;
    if (m_set[6] == 2)
      dn = 1'b1;
    else if (m_set[6] == 1)
      dn = iabs(m_ref - m_mot) <= m_set[1];
    else
      dn = m_seen != 0 && !ref_busy && iabs(m_err) < m_set[0];
    return {brake_interlock_i, torque_limited_i, main_power_i && !alarm_i,
      iabs(m_mot) > m_set[2], dn};
  endfunction

  function automatic logic [2:0] exp_out(input logic [4:0] s);
    return ~{s[m_set[5]], s[m_set[4]], s[m_set[3]]};
  endfunction

  // ----------------------------------------------
  // bus, stimulus and closing tasks
  // ----------------------------------------------
  task automatic wr(input logic [3:0] a, input int v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= 16'(v);
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    // overlarge or negative words saturate at the top of the range
    if (a < 4'h7)
      m_set[a] = (v < 0 || v > mx_t[a]) ? mx_t[a] : v;
    if (a == 4'h6 && m_set[6] != 0)
      m_seen = 0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic drive();
    @(posedge clk_i);
    err_count_i   <= 32'(m_err);
    ref_speed_i   <= 16'(m_ref);
    motor_speed_i <= 16'(m_mot);
  endtask

  task automatic move(input int bl);
    @(posedge clk_i);
    start    <= 1'b1;
    busy_len <= 4'(bl);
    @(posedge clk_i);
    start <= 1'b0;
    m_seen = 1;
    repeat (bl + 16) @(posedge clk_i);
  endtask

  task automatic check();
    logic [15:0] d;
    logic [4:0]  s;
    repeat (2) @(posedge clk_i);
    #1;
    s = exp_st();
    `CHK(out_n_o, exp_out(s))
    rd(4'h7, d);
    `CHK({d[10:8], d[5:0]}, {exp_out(s), 1'(m_seen), s})
  endtask

  task automatic print_verdict();
    $display("n_errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #500000;
    n_errors++;
    print_verdict();
  end

  // ----------------------------------------------
  // main sequence
  // ----------------------------------------------
  initial
  begin
    logic [15:0] d;
    m_set  = rst_t;
    m_seen = 0;
    m_err  = 0;
    m_ref  = 0;
    m_mot  = 0;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int a = 0; a < 7; a++)
    begin
      rd(4'(a), d);
      `CHK(d, 16'(rst_t[a]))
    end
    check();
    for (int a = 0; a < 7; a++)
    begin
      wr(4'(a), -1);
      rd(4'(a), d);
      `CHK(d, 16'(mx_t[a]))
    end
    wr(4'hC, 'h1234);
    rd(4'hC, d);
    `CHK(d, 16'h0000)
    // high word must come from the sample taken with the low word
    m_err = 32'h89AB_CDEF;
    drive();
    repeat (2) @(posedge clk_i);
    rd(4'h8, d);
    `CHK(d, 16'hCDEF)
    m_err = 32'h1234_5678;
    drive();
    rd(4'h9, d);
    `CHK(d, 16'h89AB)
    // low and high words read back to back
    @(posedge clk_i);
    addr_i <= 4'h8;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    addr_i <= 4'h9;
    #1 `CHK(rdata_o, 16'h5678)
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 `CHK(rdata_o, 16'h1234)
    wr(4'h0, 10);
    wr(4'h3, 0);
    wr(4'h6, 1);
    wr(4'h6, 0);
    m_err = 50;
    drive();
    @(posedge clk_i);
    start    <= 1'b1;
    busy_len <= 4'h8;
    m_err = 3;
    @(posedge clk_i);
    start       <= 1'b0;
    err_count_i <= 32'h0000_0003;
    repeat (4) @(posedge clk_i);
    #1 `CHK(out_n_o[0], 1'b1)
    for (int i = 0; i < 40 && confirmed !== 1'b1; i++)
      @(posedge clk_i);
    `CHK(confirmed, 1'b1)
    m_seen = 1;
    check();
    // second reset in mid-run
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    m_set  = rst_t;
    m_seen = 0;
    rd(4'h0, d);
    `CHK(d, 16'(rst_t[0]))
    check();
    for (int t = 0; t < 80; t++)
    begin
      for (int a = 0; a < 7; a++)
        wr(4'(a), rnd(mx_t[a] + 2));
      if (m_set[6] == 0 && rnd(2) == 1)
        move(1 + rnd(15));
      m_err = (m_set[0] + rnd(3) - 1) * (rnd(2) ? 1 : -1);
      m_ref = rnd(4000) - 2000;
      m_mot = m_ref + (m_set[1] + rnd(3) - 1) * (rnd(2) ? 1 : -1);
      if (rnd(2) == 1)
        wr(4'h2, iabs(m_mot) + rnd(3) - 1);
      drive();
      main_power_i      <= 1'(rnd(2));
      alarm_i           <= 1'(rnd(2));
      torque_limited_i  <= 1'(rnd(2));
      brake_interlock_i <= 1'(rnd(2));
      check();
    end
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
